/* File: verilog/quad_dac_defs.svh */
`ifndef QUAD_DAC_DEFS_SVH
`define QUAD_DAC_DEFS_SVH
// Functional notes
// - Mode 00: stage selected channel only
// - Mode 01: stage and output selected channel
// - Mode 10: stage selected, load all outputs
// - Power-down flag: top bits become setting
// - Mode 11 select-hi clear: load all staged
// - Mode 11 select-hi set: all get data
// - Mode 11 select-hi set with flag: power-down all channels
// - First byte high, second byte low
// - Update at ack falling edge after low
// - Readback cleared to zero at reset
// - Load strobe rising edge copies all staging, except to a channel that gets new data from a write in the same cycle
// - Staging register: 2 power, 16 data
// - Output register same split, immediate effect
// - Power-down write carries exactly two bytes
// - Repeated high/low pairs until stop
`define CMD_ADDR_HI 7
`define CMD_ADDR_LO 6
`define CMD_MODE_HI 5
`define CMD_MODE_LO 4
`define CMD_PICK_HI 2
`define CMD_PICK_LO 1
`define CMD_PD_FLAG 0
`define PD_SET_HI 7
`define PD_SET_LO 6
`define REG_W 18
`define DATA_W 16
`define MODE_STAGE 2'h0
`define MODE_SINGLE 2'h1
`define MODE_ALL 2'h2
`define MODE_BCAST 2'h3
`define PD_NORMAL 2'h0
`define ZERO_REG 18'h0_0000
`define BIT_LAST 3'h7
`define BIT_FIRST 3'h0
`endif

/* File: verilog/quad_dac_pkg.sv */
package quad_dac_pkg;
    // Byte receive phases
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CMD = 4'b0010,
        ST_HIGH = 4'b0100,
        ST_LOW = 4'b1000
    } rx_state_e;
    typedef logic [17:0] chan_reg_t;
endpackage : quad_dac_pkg

/* File: verilog/edge_sync.sv */
`timescale 1ns/1ps
// Two-flop synchroniser with edge pulses
module edge_sync
#(
    // Level the pin rests at, so reset leaves no false edge
    parameter logic IDLE_LEVEL = 1'b0
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Asynchronous level in
    input wire logic async_in,
    // Synchronised level and edges
    output logic level_r,
    output logic rise_r,
    output logic fall_r
);
    logic meta_r;
    logic sync_r;

    // Synchroniser chain, edge detect after second stage
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            meta_r <= IDLE_LEVEL;
            sync_r <= IDLE_LEVEL;
            level_r <= IDLE_LEVEL;
            rise_r <= 1'b0;
            fall_r <= 1'b0;
        end
        else
        begin
            meta_r <= async_in;
            sync_r <= meta_r;
            level_r <= sync_r;
            rise_r <= sync_r & ~level_r;
            fall_r <= ~sync_r & level_r;
        end
    end
endmodule : edge_sync

/* File: verilog/quad_dac_update_control.sv */
`timescale 1ns/1ps
`include "quad_dac_defs.svh"
// ****************************************
// Quad converter command decode and update
// ****************************************
module quad_dac_update_control
    import quad_dac_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Two-wire serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Extended address pins
    input wire logic ext_addr_pin_hi,
    input wire logic ext_addr_pin_lo,
    // External load strobe
    input wire logic ext_load_strobe,
    // Output register contents
    output logic [17:0] output_reg_a,
    output logic [17:0] output_reg_b,
    output logic [17:0] output_reg_c,
    output logic [17:0] output_reg_d,
    // Staging register contents
    output logic [17:0] staging_reg_a,
    output logic [17:0] staging_reg_b,
    output logic [17:0] staging_reg_c,
    output logic [17:0] staging_reg_d,
    // Pulse when any output register changes
    output logic update_pulse_r
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic scl_lvl, scl_rise, scl_fall;
    logic sda_lvl, sda_rise, sda_fall;
    logic ext_load_strobe_rise;

    // Bus lines idle high, so their chains reset high
    edge_sync #(.IDLE_LEVEL(1'b1)) u_scl (.sys_clk(sys_clk), .reset(reset), .async_in(scl_in),
        .level_r(scl_lvl), .rise_r(scl_rise), .fall_r(scl_fall));
    edge_sync #(.IDLE_LEVEL(1'b1)) u_sda (.sys_clk(sys_clk), .reset(reset), .async_in(sda_in),
        .level_r(sda_lvl), .rise_r(sda_rise), .fall_r(sda_fall));
    edge_sync #(.IDLE_LEVEL(1'b0)) u_ext_load_strobe (.sys_clk(sys_clk), .reset(reset), .async_in(ext_load_strobe),
        .level_r(), .rise_r(ext_load_strobe_rise), .fall_r());

    // Start and stop seen while clock high
    logic start_det;
    logic stop_det;
    assign start_det = sda_fall & scl_lvl;
    assign stop_det = sda_rise & scl_lvl;

    // Extended address straps, two flops before use
    logic [1:0] strap_meta_r;
    logic [1:0] strap_sync_r;
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            strap_meta_r <= 2'h0;
            strap_sync_r <= 2'h0;
        end
        else
        begin
            strap_meta_r <= {ext_addr_pin_hi, ext_addr_pin_lo};
            strap_sync_r <= strap_meta_r;
        end
    end

    // ****************************************
    // Byte receiver
    // ****************************************
    rx_state_e state_r;          // Current byte phase
    logic [2:0] bit_cnt_r;       // Bits taken in this byte
    logic [7:0] shift_r;         // Incoming byte
    logic ack_phase_r;           // Ninth clock in progress
    logic pend_ack_r;            // Byte taken, ack window not yet open
    logic [7:0] command_byte_reg;
    logic [7:0] upper_data_byte_reg;
    logic [7:0] lower_data_byte_reg;
    logic byte_done;             // Eighth bit just sampled
    logic ack_end;               // Falling edge closing ack clock
    logic pd_seen_r;             // Power-down pair already taken
    logic addr_ok;               // Extended address match

    assign byte_done = scl_rise & ~ack_phase_r & (bit_cnt_r == `BIT_LAST) & (state_r != ST_IDLE);
    assign ack_end = scl_fall & ack_phase_r;
    assign addr_ok = (command_byte_reg[`CMD_ADDR_HI] == strap_sync_r[1]) &
                     (command_byte_reg[`CMD_ADDR_LO] == strap_sync_r[0]);

    // Shift register and bit count
    always_ff @(posedge sys_clk)
    begin
        if (reset || start_det || stop_det)
        begin
            bit_cnt_r <= `BIT_FIRST;
            shift_r <= 8'h00;
        end
        else if (scl_rise && !ack_phase_r)
        begin
            shift_r <= {shift_r[6:0], sda_lvl};
            bit_cnt_r <= bit_cnt_r + 3'h1;
        end
    end

    // Ack phase flag: set at eighth fall, cleared at ninth fall
    always_ff @(posedge sys_clk)
    begin
        if (reset || start_det || stop_det)
        begin
            ack_phase_r <= 1'b0;
        end
        else if (scl_fall && pend_ack_r)
        begin
            ack_phase_r <= 1'b1;
        end
        else if (ack_end)
        begin
            ack_phase_r <= 1'b0;
        end
    end

    // Ack drive: pull data low during ninth clock
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            sda_out <= 1'b1;
            sda_oe_n <= 1'b1;
        end
        else
        begin
            sda_out <= 1'b0;
            if (scl_fall && pend_ack_r)
            begin
                sda_oe_n <= 1'b0;
            end
            else if (ack_end || start_det || stop_det)
            begin
                sda_oe_n <= 1'b1;
            end
        end
    end

    // Byte accepted, waiting for ack window
    always_ff @(posedge sys_clk)
    begin
        if (reset || start_det || stop_det)
        begin
            pend_ack_r <= 1'b0;
        end
        else if (byte_done)
        begin
            pend_ack_r <= 1'b1;
        end
        else if (scl_fall && pend_ack_r)
        begin
            pend_ack_r <= 1'b0;
        end
    end

    // Byte phase sequencing; command byte comes straight after start
    always_ff @(posedge sys_clk)
    begin
        if (reset || stop_det)
        begin
            state_r <= ST_IDLE;
        end
        else if (start_det)
        begin
            state_r <= ST_CMD;
        end
        else if (byte_done)
        begin
            case (state_r)
                ST_CMD: state_r <= ST_HIGH;
                ST_HIGH: state_r <= ST_LOW;
                ST_LOW: state_r <= ST_HIGH;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Capture received bytes
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            command_byte_reg <= 8'h00;
            upper_data_byte_reg <= 8'h00;
            lower_data_byte_reg <= 8'h00;
        end
        else if (byte_done)
        begin
            case (state_r)
                ST_CMD: command_byte_reg <= {shift_r[6:0], sda_lvl};
                ST_HIGH: upper_data_byte_reg <= {shift_r[6:0], sda_lvl};
                ST_LOW: lower_data_byte_reg <= {shift_r[6:0], sda_lvl};
                default: command_byte_reg <= command_byte_reg;
            endcase
        end
    end

    // Low byte received; act at its ack falling edge
    logic low_pending_r;
    always_ff @(posedge sys_clk)
    begin
        if (reset || start_det || stop_det)
        begin
            low_pending_r <= 1'b0;
        end
        else if (byte_done && state_r == ST_LOW)
        begin
            low_pending_r <= 1'b1;
        end
        else if (ack_end)
        begin
            low_pending_r <= 1'b0;
        end
    end

    // Power-down write takes one pair only
    always_ff @(posedge sys_clk)
    begin
        if (reset || start_det || stop_det)
        begin
            pd_seen_r <= 1'b0;
        end
        else if (ack_end && low_pending_r && command_byte_reg[`CMD_PD_FLAG])
        begin
            pd_seen_r <= 1'b1;
        end
    end

    // ****************************************
    // Update decode
    // ****************************************
    logic [1:0] mode;
    logic [1:0] pick;
    logic fire;
    logic [17:0] new_word;
    logic [3:0] stage_we;
    logic [3:0] out_from_new;
    logic [3:0] out_from_stage;

    assign mode = {command_byte_reg[`CMD_MODE_HI], command_byte_reg[`CMD_MODE_LO]};
    assign pick = {command_byte_reg[`CMD_PICK_HI], command_byte_reg[`CMD_PICK_LO]};
    assign fire = ack_end & low_pending_r & ~pd_seen_r;

    // Build new 18-bit word from bytes
    always_comb
    begin
        if (command_byte_reg[`CMD_PD_FLAG])
        begin
            // Power setting only, data zero
            new_word = {upper_data_byte_reg[`PD_SET_HI], upper_data_byte_reg[`PD_SET_LO], 16'h0000};
        end
        else
        begin
            // Normal code with high byte first
            new_word = {`PD_NORMAL, upper_data_byte_reg, lower_data_byte_reg};
        end
    end

    // Per-channel write enables
    always_comb
    begin
        stage_we = 4'h0;
        out_from_new = 4'h0;
        out_from_stage = 4'h0;
        if (fire)
        begin
            case (mode)
                `MODE_STAGE:
                begin
                    if (addr_ok) stage_we[pick] = 1'b1;
                end
                `MODE_SINGLE:
                begin
                    if (addr_ok)
                    begin
                        stage_we[pick] = 1'b1;
                        out_from_new[pick] = 1'b1;
                    end
                end
                `MODE_ALL:
                begin
                    if (addr_ok)
                    begin
                        stage_we[pick] = 1'b1;
                        out_from_new[pick] = 1'b1;
                        out_from_stage = ~(4'h1 << pick);
                    end
                end
                `MODE_BCAST:
                begin
                    // Address and low pick ignored
                    if (!command_byte_reg[`CMD_PICK_HI])
                    begin
                        out_from_stage = 4'hf;
                    end
                    else
                    begin
                        out_from_new = 4'hf;
                    end
                end
                default:
                begin
                    stage_we = 4'h0;
                end
            endcase
        end
    end

    // ****************************************
    // Staging and output registers
    // ****************************************
    chan_reg_t stage_r [4];
    chan_reg_t out_r [4];

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch = ch + 1)
        begin : g_chan
            // Staging register, cleared at reset
            always_ff @(posedge sys_clk)
            begin
                if (reset)
                begin
                    stage_r[ch] <= `ZERO_REG;
                end
                else if (stage_we[ch])
                begin
                    stage_r[ch] <= new_word;
                end
            end

            // Output register; strobe edge copies staging
            always_ff @(posedge sys_clk)
            begin
                if (reset)
                begin
                    out_r[ch] <= `ZERO_REG;
                end
                else if (out_from_new[ch])
                begin
                    out_r[ch] <= new_word;
                end
                else if (out_from_stage[ch] || ext_load_strobe_rise)
                begin
                    out_r[ch] <= stage_r[ch];
                end
            end
        end
    endgenerate

    // Output ports straight from flops
    assign staging_reg_a = stage_r[0];
    assign staging_reg_b = stage_r[1];
    assign staging_reg_c = stage_r[2];
    assign staging_reg_d = stage_r[3];
    assign output_reg_a = out_r[0];
    assign output_reg_b = out_r[1];
    assign output_reg_c = out_r[2];
    assign output_reg_d = out_r[3];

    // Update indication pulse
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            update_pulse_r <= 1'b0;
        end
        else
        begin
            update_pulse_r <= (|out_from_new) | (|out_from_stage) | ext_load_strobe_rise;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_fire_single;
        fire && mode == `MODE_SINGLE && addr_ok;
    endsequence

    property p_stage_only;
        @(posedge sys_clk) disable iff (reset)
        (fire && mode == `MODE_STAGE && !ext_load_strobe_rise) |=> $stable(out_r[0]) && $stable(out_r[3]);
    endproperty
    a_stage_only: assert property (p_stage_only) else $error("Stage mode changed an output");

    property p_single;
        @(posedge sys_clk) disable iff (reset)
        s_fire_single ##1 1'b1 |-> out_r[$past(pick)] == $past(new_word);
    endproperty
    a_single: assert property (p_single) else $error("Single update missed output");

    property p_all;
        @(posedge sys_clk) disable iff (reset)
        (fire && mode == `MODE_ALL && addr_ok && pick != 2'h0) |=> out_r[0] == $past(stage_r[0]);
    endproperty
    a_all: assert property (p_all) else $error("All-load did not copy staging");

    property p_pd_word;
        @(posedge sys_clk) disable iff (reset)
        command_byte_reg[`CMD_PD_FLAG] |-> new_word[15:0] == 16'h0000;
    endproperty
    a_pd_word: assert property (p_pd_word) else $error("Power-down word carries data");

    property p_bcast_stage;
        @(posedge sys_clk) disable iff (reset)
        (fire && mode == `MODE_BCAST && !command_byte_reg[`CMD_PICK_HI])
            |=> out_r[1] == $past(stage_r[1]) && out_r[2] == $past(stage_r[2]);
    endproperty
    a_bcast_stage: assert property (p_bcast_stage) else $error("Broadcast load failed");

    property p_bcast_new;
        @(posedge sys_clk) disable iff (reset)
        (fire && mode == `MODE_BCAST && command_byte_reg[`CMD_PICK_HI])
            |=> out_r[0] == $past(new_word) && out_r[3] == $past(new_word);
    endproperty
    a_bcast_new: assert property (p_bcast_new) else $error("Broadcast data not applied");

    property p_ext_load_strobe;
        @(posedge sys_clk) disable iff (reset)
        (ext_load_strobe_rise && !fire) |=> out_r[2] == $past(stage_r[2]) && update_pulse_r;
    endproperty
    a_ext_load_strobe: assert property (p_ext_load_strobe) else $error("Load strobe did not copy staging");

    property p_fire_on_ack;
        @(posedge sys_clk) disable iff (reset)
        fire |-> !scl_lvl && $past(scl_lvl);
    endproperty
    a_fire_on_ack: assert property (p_fire_on_ack) else $error("Update off ack edge");
endmodule : quad_dac_update_control

/* File: tb/serial_host_model.sv */
`timescale 1ns/1ps
// **********
// Two-wire bus master model
// **********
module serial_host_model
(
    // Clock
    input wire logic sys_clk,
    // Resolved data line
    input wire logic sda_line,
    // Clock and data driven by the master, data released high
    output logic scl_line,
    output logic sda_host,
    // Count of missing acknowledges
    output int nack_count
);
    // Bus idle: both lines released high
    initial
    begin
        scl_line = 1'b1;
        sda_host = 1'b1;
        nack_count = 0;
    end

    // Wait some system clock edges
    task automatic hold(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : hold

    // One bit, data moves only while the clock is low
    task automatic clock_bit(input logic b, output logic seen);
        hold(1);
        sda_host <= b;
        // Long low phase lets the device free the line before the rise
        hold(4);
        scl_line <= 1'b1;
        hold(2);
        seen = sda_line;
        hold(1);
        scl_line <= 1'b0;
    endtask : clock_bit

    // Byte out MSB first, then free the line for the acknowledge
    task automatic send_byte(input logic [7:0] b);
        logic seen;
        for (int i = 7; i >= 0; i--)
            clock_bit(b[i], seen);
        clock_bit(1'b1, seen);
        // Released line still high means no acknowledge
        if (seen !== 1'b0)
            nack_count++;
    endtask : send_byte

    // Data falls while the clock stands high
    task automatic start_cond();
        hold(2);
        sda_host <= 1'b0;
        hold(4);
        scl_line <= 1'b0;
    endtask : start_cond

    // Data rises while the clock stands high, then idle
    task automatic stop_cond();
        hold(1);
        sda_host <= 1'b0;
        hold(3);
        scl_line <= 1'b1;
        hold(4);
        sda_host <= 1'b1;
        hold(8);
    endtask : stop_cond

    // Command and one high/low pair; a power-down write is exactly this
    task automatic write_pair(input logic [7:0] cmd, input logic [15:0] word);
        start_cond();
        send_byte(cmd);
        send_byte(word[15:8]);
        send_byte(word[7:0]);
        stop_cond();
    endtask : write_pair
endmodule : serial_host_model

/* File: tb/testbench.sv */
`timescale 1ns/1ps
// **********
// Update control testbench
// **********
module testbench;
    import quad_dac_pkg::*;
    // Clock, reset and pins
    logic sys_clk;
    logic reset;
    logic sda_out;
    logic sda_oe_n;
    logic ext_load_strobe;
    logic update_pulse_r;
    wire scl_line;
    wire sda_host;
    // Open-drain line with pull-up
    wire sda_line = sda_host & (sda_oe_n | sda_out);
    int nack_count;
    // Register views and expectations
    chan_reg_t out_a, out_b, out_c, out_d;
    chan_reg_t stg_a, stg_b, stg_c, stg_d;
    chan_reg_t out_w[4];
    chan_reg_t stg_w[4];
    // Extended address straps
    logic strap_hi;
    logic strap_lo;
    chan_reg_t out_x[4] = '{default: '0};
    chan_reg_t stg_x[4] = '{default: '0};
    int num_errors = 0;
    int samples_checked = 0;
    int pulses = 0;

    // 25 MHz clock
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Count output update pulses
    always @(posedge sys_clk)
        if (update_pulse_r === 1'b1)
            pulses++;

    quad_dac_update_control i_quad_dac_update_control (
        .sys_clk(sys_clk), .reset(reset), .scl_in(scl_line), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .ext_addr_pin_hi(strap_hi), .ext_addr_pin_lo(strap_lo),
        .ext_load_strobe(ext_load_strobe), .output_reg_a(out_a), .output_reg_b(out_b),
        .output_reg_c(out_c), .output_reg_d(out_d), .staging_reg_a(stg_a),
        .staging_reg_b(stg_b), .staging_reg_c(stg_c), .staging_reg_d(stg_d),
        .update_pulse_r(update_pulse_r));

    // Channel views gathered for the compare loops
    assign out_w[0] = out_a;
    assign out_w[1] = out_b;
    assign out_w[2] = out_c;
    assign out_w[3] = out_d;
    assign stg_w[0] = stg_a;
    assign stg_w[1] = stg_b;
    assign stg_w[2] = stg_c;
    assign stg_w[3] = stg_d;

    serial_host_model i_serial_host_model (
        .sys_clk(sys_clk), .sda_line(sda_line), .scl_line(scl_line),
        .sda_host(sda_host), .nack_count(nack_count));

    // Compare one value
    task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Compare all outputs, staging optionally
    task automatic check_regs(input bit with_stg);
        for (int c = 0; c < 4; c++)
        begin
            check("output", out_w[c], out_x[c]);
            if (with_stg)
                check("staging", stg_w[c], stg_x[c]);
        end
    endtask : check_regs

    // One frame from command fields; straps are 2'b10
    task automatic wr(input logic [1:0] a, m, p, input logic pd, input logic [15:0] w);
        i_serial_host_model.write_pair({a, m, 1'b0, p, pd}, w);
    endtask : wr

    // Staging only, every channel
    task automatic t_stage();
        int p0;
        p0 = pulses;
        for (int c = 0; c < 4; c++)
        begin
            stg_x[c] = {2'b00, 16'hA5C0 | 16'(c)};
            wr(2'b10, 2'b00, 2'(c), 1'b0, stg_x[c][15:0]);
        end
        check_regs(1'b1);
        check("pulses", 18'(pulses - p0), 18'h0_0000);
    endtask : t_stage

    // Single update, nothing before the low byte, repeated pairs
    task automatic t_single();
        int p0;
        p0 = pulses;
        i_serial_host_model.start_cond();
        i_serial_host_model.send_byte(8'h92);
        i_serial_host_model.send_byte(8'hBE);
        i_serial_host_model.hold(8);
        check_regs(1'b1);
        i_serial_host_model.send_byte(8'hEF);
        i_serial_host_model.hold(8);
        stg_x[1] = 18'h0_BEEF;
        out_x[1] = 18'h0_BEEF;
        check_regs(1'b1);
        i_serial_host_model.send_byte(8'h13);
        i_serial_host_model.send_byte(8'h57);
        i_serial_host_model.stop_cond();
        stg_x[1] = 18'h0_1357;
        out_x[1] = 18'h0_1357;
        check_regs(1'b1);
        check("pulses", 18'(pulses - p0), 18'h0_0002);
    endtask : t_single

    // Stage one channel and load all
    task automatic t_all();
        stg_x[2] = 18'h0_8001;
        out_x = stg_x;
        wr(2'b10, 2'b10, 2'b10, 1'b0, 16'h8001);
        check_regs(1'b1);
    endtask : t_all

    // Power-down codes, staged and applied
    task automatic t_pd();
        stg_x[0] = 18'h1_0000;
        wr(2'b10, 2'b00, 2'b00, 1'b1, 16'h4000);
        stg_x[3] = 18'h2_0000;
        out_x[3] = 18'h2_0000;
        wr(2'b10, 2'b01, 2'b11, 1'b1, 16'h8000);
        check_regs(1'b1);
    endtask : t_pd

    // Wrong extended address, no effect; then straps moved to match
    task automatic t_mismatch();
        wr(2'b01, 2'b01, 2'b00, 1'b0, 16'hDEAD);
        check_regs(1'b1);
        strap_hi <= 1'b0;
        strap_lo <= 1'b1;
        wr(2'b01, 2'b01, 2'b00, 1'b0, 16'hDEAD);
        stg_x[0] = 18'h0_DEAD;
        out_x[0] = 18'h0_DEAD;
        check_regs(1'b1);
        strap_hi <= 1'b1;
        strap_lo <= 1'b0;
    endtask : t_mismatch

    // Strobe only after staging is written
    task automatic t_strobe();
        stg_x[0] = 18'h0_7777;
        wr(2'b10, 2'b00, 2'b00, 1'b0, 16'h7777);
        ext_load_strobe <= 1'b1;
        i_serial_host_model.hold(6);
        ext_load_strobe <= 1'b0;
        i_serial_host_model.hold(6);
        out_x = stg_x;
        check_regs(1'b1);
    endtask : t_strobe

    // Broadcast forms with foreign address, select-lo set in all but the power-down one
    task automatic t_bcast();
        stg_x[1] = 18'h0_2468;
        wr(2'b10, 2'b00, 2'b01, 1'b0, 16'h2468);
        out_x = stg_x;
        wr(2'b01, 2'b11, 2'b01, 1'b0, 16'hFFFF);
        check_regs(1'b1);
        out_x = '{default: 18'h0_C3C3};
        wr(2'b01, 2'b11, 2'b11, 1'b0, 16'hC3C3);
        check_regs(1'b0);
        out_x = '{default: 18'h3_0000};
        wr(2'b00, 2'b11, 2'b10, 1'b1, 16'hC000);
        check_regs(1'b0);
        check("nacks", 18'(nack_count), 18'h0_0000);
    endtask : t_bcast

    // Verdict and end of run
    task automatic end_of_test();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    // Hang guard
    initial
    begin
        repeat (40000) @(posedge sys_clk);
        num_errors++;
        $display("BAD watchdog expected finish seen hang");
        end_of_test();
    end

    // Main sequence
    initial
    begin
        reset = 1'b1;
        ext_load_strobe = 1'b0;
        strap_hi = 1'b1;
        strap_lo = 1'b0;
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (2) @(posedge sys_clk);
        check_regs(1'b1);
        t_stage();
        t_single();
        t_all();
        t_pd();
        t_mismatch();
        t_strobe();
        t_bcast();
        end_of_test();
    end
endmodule : testbench
